// ===== shared/dac_rb_params.svh
// Constants for the readback decoder and bank-select register bank
`ifndef DAC_RB_PARAMS_SVH
`define DAC_RB_PARAMS_SVH

`define FRAME_W        24
`define WORD_W         16
`define MODE_MSB       23
`define MODE_LSB       22
`define ADDR_MSB       21
`define ADDR_LSB       16
`define CHAN_MSB       18
`define CHAN_LSB       16

`define MODE_SPECIAL   2'h0
`define MODE_GAIN      2'h1
`define MODE_OFFSET    2'h2
`define MODE_INPUT     2'h3

`define SF_CTRL        6'h01
`define SF_OFFSET_DAC_ZERO 6'h02
`define SF_OFFSET_DAC_ONE  6'h03
`define SF_RB_SEL      6'h05
`define SF_BANK_LO     6'h06
`define SF_BANK_HI     6'h07
`define SF_BANK_ALL    6'h0b
`define SF_GPIO        6'h0d

`define RB_CODE_MSB    15
`define RB_CODE_LSB    7
`define RB_KIND_MSB    14
`define RB_KIND_LSB    13
`define RB_CHAN_MSB    9
`define RB_CHAN_LSB    7
`define RB_SPECIAL_BIT 8
`define RB_CTRL        9'h101
`define RB_OFFSET_DAC_ZERO 9'h102
`define RB_OFFSET_DAC_ONE  9'h103
`define RB_BANK_LO     9'h106
`define RB_BANK_HI     9'h107
`define RB_GPIO        9'h10b

`define KIND_IN_A      2'h0
`define KIND_IN_B      2'h1
`define KIND_OFFSET    2'h2
`define KIND_GAIN      2'h3

`define CTRL_W         3
`define CTRL_INB_BIT   2
`define CTRL_RST       3'h0
`define OFS_W          14
`define OFS_RST        14'h0000
`define BANK_W         4
`define BANK_RST       4'h0
`define BANK_HI_LSB    4
`define BANK_HI_MSB    7
`define GPIO_DIR_BIT   1
`define GPIO_DATA_BIT  0
`define MEM_AW         5
`define MEM_DEPTH      32
`define WORD_ZERO      16'h0000

`endif

// ===== shared/dac_rb_pkg.sv
// Types and decode function for the readback register bank
`default_nettype none
`include "dac_rb_params.svh"
package dac_rb_pkg;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b001,
		ST_FETCH = 3'b010,
		ST_HOLD  = 3'b100
	} rb_state_t;

	typedef enum logic [2:0] {
		SRC_NONE    = 3'h0,
		SRC_MEM     = 3'h1,
		SRC_CTRL    = 3'h2,
		SRC_OFFSET_DAC_ZERO = 3'h3,
		SRC_OFFSET_DAC_ONE  = 3'h4,
		SRC_BANK_LO = 3'h5,
		SRC_BANK_HI = 3'h6,
		SRC_GPIO    = 3'h7
	} rb_src_t;

	function automatic rb_src_t rb_decode(input logic [8:0] code);
		rb_decode = SRC_NONE;
		if (!code[`RB_SPECIAL_BIT]) begin
			rb_decode = SRC_MEM;
		end else begin
			case (code)
				`RB_CTRL:    rb_decode = SRC_CTRL;
				`RB_OFFSET_DAC_ZERO: rb_decode = SRC_OFFSET_DAC_ZERO;
				`RB_OFFSET_DAC_ONE:  rb_decode = SRC_OFFSET_DAC_ONE;
				`RB_BANK_LO: rb_decode = SRC_BANK_LO;
				`RB_BANK_HI: rb_decode = SRC_BANK_HI;
				`RB_GPIO:    rb_decode = SRC_GPIO;
				default:     rb_decode = SRC_NONE;
			endcase
		end
	endfunction : rb_decode

endpackage : dac_rb_pkg
`default_nettype wire

// ===== shared/chan_mem_if.sv
// Port bundle between the decoder and the per-channel word memory
`timescale 1ns/1ps
`default_nettype none
`include "dac_rb_params.svh"
interface chan_mem_if;
	logic                 we;
	logic [`MEM_AW-1:0]   waddr;
	logic [`WORD_W-1:0]   wdata;
	logic                 re;
	logic [`MEM_AW-1:0]   raddr;
	logic [`WORD_W-1:0]   rdata;

	modport ctrl (output we, waddr, wdata, re, raddr, input rdata);
	modport mem  (input we, waddr, wdata, re, raddr, output rdata);
endinterface : chan_mem_if
`default_nettype wire

// ===== hw/chan_word_mem.sv
// Per-channel input, offset and gain words with registered read data
`timescale 1ns/1ps
`default_nettype none
`include "dac_rb_params.svh"
module chan_word_mem (
	input wire logic clk_in,
	input wire logic rstn_in,
	chan_mem_if.mem  port_m
);
	// Array not reset: it models plain RAM
	logic [`WORD_W-1:0] words [`MEM_DEPTH];

	always_ff @(posedge clk_in) begin
		if (port_m.we) begin
			words[port_m.waddr] <= port_m.wdata;
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			port_m.rdata <= `WORD_ZERO;
		end else if (port_m.re) begin
			port_m.rdata <= words[port_m.raddr];
		end
	end
endmodule : chan_word_mem
`default_nettype wire

// ===== hw/dac_readback_bank_select.sv
// Readback address decoder and per-channel bank-select registers
`timescale 1ns/1ps
`default_nettype none
`include "dac_rb_params.svh"
//
// Overview of operation
// R1 - Select codes 000..011 in top bits return channel input A, B, offset, gain
// R2 - Codes 1_0000_0xxx return control, offset DAC zero/one, bank-select low/high
// R3 - Code 1_0000_1011 returns the general-purpose pin level in bit zero
// R4 - Lowest seven data bits never affect which register is returned
// R5 - Host sends zeros in lowest seven bits when reading the pin
// R6 - Bank-select low holds channels 0-3, high holds 4-7; upper bits reserved
// R7 - Bank bit 0 routes bank A to converter, 1 routes bank B
// R8 - Host sends select frame, then a no-op frame that shifts data out
// R9 - Readback select is register-select value 000101, address in data bits
// R10 - Reserved codes return all zeros and change no register
module dac_readback_bank_select
	import dac_rb_pkg::*;
(
	input  wire logic                 clk_in,
	input  wire logic                 rstn_in,
	input  wire logic                 frame_strobe_in,
	input  wire logic [`FRAME_W-1:0]  frame_word_in,
	input  wire logic                 gpio_pin_in,
	input  wire logic                 temp_alarm_in,
	output var  logic [`WORD_W-1:0]   rb_word_out,
	output var  logic                 rb_ready_out,
	output var  logic [7:0]           bank_b_sel_out,
	output var  logic                 gpio_out,
	output var  logic                 gpio_oe_out
);
	////////////////////////////////////////////////////////////////////////////
	chan_mem_if mem_bus ();

	chan_word_mem chan_word_mem_i (
		.clk_in  (clk_in),
		.rstn_in (rstn_in),
		.port_m  (mem_bus.mem)
	);

	logic [1:0]           mode;
	logic [5:0]           sel;
	logic [`WORD_W-1:0]   fdata;
	logic                 special;
	logic                 rb_sel_frame;
	rb_state_t            state_ff;
	rb_state_t            nxt_state;
	rb_src_t              src_ff;
	logic [`CTRL_W-1:0]   ctrl_ff;
	logic [`OFS_W-1:0]    offset_dac_zero_ff;
	logic [`OFS_W-1:0]    offset_dac_one_ff;
	logic [`BANK_W-1:0]   bank_select_low_ff;
	logic [`BANK_W-1:0]   bank_select_high_ff;
	logic                 gpio_level;
	logic [`WORD_W-1:0]   nxt_word;
	logic [1:0]           wr_kind;

	assign mode         = frame_word_in[`MODE_MSB:`MODE_LSB];
	assign sel          = frame_word_in[`ADDR_MSB:`ADDR_LSB];
	assign fdata        = frame_word_in[`WORD_W-1:0];
	assign special      = (mode == `MODE_SPECIAL);
	assign rb_sel_frame = frame_strobe_in && special && (sel == `SF_RB_SEL);  // [R9]
	assign gpio_level   = gpio_oe_out ? gpio_out : gpio_pin_in;

	////////////////////////////////////////////////////////////////////////////
	// Channel word writes go straight to memory
	always_comb begin
		case (mode)
			`MODE_INPUT:  wr_kind = ctrl_ff[`CTRL_INB_BIT] ? `KIND_IN_B : `KIND_IN_A;
			`MODE_OFFSET: wr_kind = `KIND_OFFSET;
			`MODE_GAIN:   wr_kind = `KIND_GAIN;
			default:      wr_kind = `KIND_IN_A;
		endcase
	end

	assign mem_bus.we    = frame_strobe_in && !special;
	assign mem_bus.waddr = {wr_kind, frame_word_in[`CHAN_MSB:`CHAN_LSB]};
	assign mem_bus.wdata = fdata;
	// Low seven bits not part of the read address
	assign mem_bus.re    = rb_sel_frame;  // [R4]
	assign mem_bus.raddr = {fdata[`RB_KIND_MSB:`RB_KIND_LSB],
		fdata[`RB_CHAN_MSB:`RB_CHAN_LSB]};  // [R1]

	////////////////////////////////////////////////////////////////////////////
	// Special-function register writes
	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			bank_select_low_ff  <= `BANK_RST;
			bank_select_high_ff <= `BANK_RST;
		end else if (frame_strobe_in && special) begin
			case (sel)
				`SF_BANK_LO:  bank_select_low_ff <= fdata[`BANK_W-1:0];  // [R6]
				`SF_BANK_HI:  bank_select_high_ff <= fdata[`BANK_W-1:0];  // [R6]
				`SF_BANK_ALL: begin
					bank_select_low_ff  <= fdata[`BANK_W-1:0];
					bank_select_high_ff <= fdata[`BANK_HI_MSB:`BANK_HI_LSB];
				end
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			ctrl_ff <= `CTRL_RST;
			offset_dac_zero_ff <= `OFS_RST;
			offset_dac_one_ff  <= `OFS_RST;
		end else if (frame_strobe_in && special) begin
			case (sel)
				`SF_CTRL:            ctrl_ff <= fdata[`CTRL_W-1:0];
				`SF_OFFSET_DAC_ZERO: offset_dac_zero_ff <= fdata[`OFS_W-1:0];
				`SF_OFFSET_DAC_ONE:  offset_dac_one_ff <= fdata[`OFS_W-1:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			gpio_out    <= 1'b0;
			gpio_oe_out <= 1'b0;
		end else if (frame_strobe_in && special && (sel == `SF_GPIO)) begin
			gpio_oe_out <= fdata[`GPIO_DIR_BIT];
			gpio_out    <= fdata[`GPIO_DATA_BIT];
		end
	end

	// Bit set means the channel feeds from bank B
	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			bank_b_sel_out <= {`BANK_RST, `BANK_RST};
		end else begin
			bank_b_sel_out <= {bank_select_high_ff, bank_select_low_ff};  // [R7]
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Readback sequence: select, fetch, hold until the next frame
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			ST_IDLE:  if (rb_sel_frame) nxt_state = ST_FETCH;
			// Frames are many cycles apart, so none lands here
			ST_FETCH: nxt_state = ST_HOLD;
			ST_HOLD: begin
				if (rb_sel_frame) nxt_state = ST_FETCH;
				else if (frame_strobe_in) nxt_state = ST_IDLE;  // [R8]
			end
			default:  nxt_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			state_ff <= ST_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			src_ff <= SRC_NONE;
		end else if (rb_sel_frame) begin
			src_ff <= rb_decode(fdata[`RB_CODE_MSB:`RB_CODE_LSB]);  // [R4]
		end
	end

	always_comb begin
		case (src_ff)
			SRC_MEM:     nxt_word = mem_bus.rdata;  // [R1]
			SRC_CTRL:    nxt_word = {11'h000, temp_alarm_in, 1'b0, ctrl_ff};  // [R2]
			SRC_OFFSET_DAC_ZERO: nxt_word = {2'h0, offset_dac_zero_ff};  // [R2]
			SRC_OFFSET_DAC_ONE:  nxt_word = {2'h0, offset_dac_one_ff};  // [R2]
			SRC_BANK_LO: nxt_word = {12'h000, bank_select_low_ff};  // [R2] [R6]
			SRC_BANK_HI: nxt_word = {12'h000, bank_select_high_ff};  // [R2] [R6]
			SRC_GPIO:    nxt_word = {15'h0000, gpio_level};  // [R3]
			default:     nxt_word = `WORD_ZERO;  // [R10]
		endcase
	end

	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			rb_word_out  <= `WORD_ZERO;
			rb_ready_out <= 1'b0;
		end else begin
			if (state_ff == ST_FETCH) begin
				rb_word_out <= nxt_word;
			end
			rb_ready_out <= (nxt_state == ST_HOLD);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rstn_in);

	property p_mem_word;
		(state_ff == ST_FETCH && src_ff == SRC_MEM) |=> rb_word_out == $past(mem_bus.rdata);
	endproperty
	a_mem_word: assert property (p_mem_word) else $error("channel word not returned"); // [R1]

	property p_select_ready;
		rb_sel_frame ##1 !frame_strobe_in |=> rb_ready_out;
	endproperty
	a_select_ready: assert property (p_select_ready) else $error("readback not ready"); // [R9]

	property p_bank_lo_read;
		(state_ff == ST_FETCH && src_ff == SRC_BANK_LO) |=>
			rb_word_out == {12'h000, $past(bank_select_low_ff)};
	endproperty
	a_bank_lo_read: assert property (p_bank_lo_read) else $error("bank low readback wrong"); // [R2]

	property p_gpio_read;
		(state_ff == ST_FETCH && src_ff == SRC_GPIO) |=>
			rb_word_out[15:1] == 15'h0000 && rb_word_out[0] == $past(gpio_level);
	endproperty
	a_gpio_read: assert property (p_gpio_read) else $error("pin readback wrong"); // [R3]

	// Control code with any low bits must still pick the control register
	property p_low_bits_ignored;
		(rb_sel_frame && fdata[`RB_CODE_MSB:`RB_CODE_LSB] == `RB_CTRL) |=>
			src_ff == SRC_CTRL;
	endproperty
	a_low_bits_ignored: assert property (p_low_bits_ignored) else $error("decode wrong"); // [R4]

	property p_bank_lo_write;
		(frame_strobe_in && special && sel == `SF_BANK_LO) |-> ##2
			bank_b_sel_out[3:0] == $past(fdata[3:0], 2) && $stable(bank_b_sel_out[7:4]);
	endproperty
	a_bank_lo_write: assert property (p_bank_lo_write) else $error("bank low not routed"); // [R6]

	property p_bank_hi_write;
		(frame_strobe_in && special && sel == `SF_BANK_HI) |-> ##2
			bank_b_sel_out[7:4] == $past(fdata[3:0], 2);
	endproperty
	a_bank_hi_write: assert property (p_bank_hi_write) else $error("bank high not routed"); // [R7]

	property p_shift_out;
		(rb_ready_out && frame_strobe_in && !rb_sel_frame) |=> !rb_ready_out;
	endproperty
	a_shift_out: assert property (p_shift_out) else $error("ready kept after shift"); // [R8]

	property p_reserved_zero;
		(state_ff == ST_FETCH && src_ff == SRC_NONE) |=>
			rb_word_out == `WORD_ZERO && $stable(bank_select_low_ff) && $stable(ctrl_ff);
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("reserved not zero"); // [R10]

	c_mem_read:  cover property (rb_sel_frame && !fdata[15] ##2 rb_ready_out);
	c_gpio_read: cover property (state_ff == ST_FETCH && src_ff == SRC_GPIO);
	c_bank_b:    cover property (bank_b_sel_out == 8'hff);
	c_back2back: cover property (rb_ready_out && rb_sel_frame);
endmodule : dac_readback_bank_select
`default_nettype wire

// ===== dv/dac_host_model.sv
// Host-side frame driver for register writes and readback
`timescale 1ns/1ps
`default_nettype none
`include "dac_rb_params.svh"
module dac_host_model (
	input  wire logic                clk_in,
	output var  logic                frame_strobe_out,
	output var  logic [`FRAME_W-1:0] frame_word_out
);
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		frame_strobe_out = 1'b0;
		frame_word_out   = 24'h5a5a5a;
	end

	// Word lines inverted between frames so stale data never looks valid
	// Four-cycle spacing keeps clear of the fetch cycle after a select
	task automatic send_frame(input logic [`FRAME_W-1:0] w);
		@(posedge clk_in);
		frame_strobe_out <= 1'b1;
		frame_word_out   <= w;
		@(posedge clk_in);
		frame_strobe_out <= 1'b0;
		frame_word_out   <= ~w;
		repeat (2) @(posedge clk_in);
	endtask : send_frame

	// Select frame, then a no-op frame that shifts the word out
	task automatic read_frame(input logic [8:0] code, input logic [6:0] low);
		send_frame({2'h0, `SF_RB_SEL, code, low});
		send_frame(24'h000000);
	endtask : read_frame
endmodule : dac_host_model
`default_nettype wire

// ===== dv/dac_readback_bank_select_test.sv
// Self-checking testbench for the readback decoder and bank-select registers
`timescale 1ns/1ps
`default_nettype none
`include "dac_rb_params.svh"
module dac_readback_bank_select_test;
	logic                clk_in;
	logic                rstn_in;
	logic                gpio_pin_in;
	logic                temp_alarm_in;
	logic                frame_strobe_in;
	logic [`FRAME_W-1:0] frame_word_in;
	logic [15:0]         rb_word_out;
	logic                rb_ready_out;
	logic [7:0]          bank_b_sel_out;
	logic                gpio_out;
	logic                gpio_oe_out;
	logic                ready_seen;
	logic [15:0]         lfsr_ff;
	logic [15:0]         d;
	logic [15:0]         mem_w [4][8];
	logic [8:0]          rsv   [4];
	logic [15:0]         exp_q [$];
	int                  bad_count;
	int                  num_checks;

	////////////////////////////////////////////////////////////////////////////////
	dac_readback_bank_select dac_readback_bank_select_i (
		.clk_in          (clk_in),
		.rstn_in         (rstn_in),
		.frame_strobe_in (frame_strobe_in),
		.frame_word_in   (frame_word_in),
		.gpio_pin_in     (gpio_pin_in),
		.temp_alarm_in   (temp_alarm_in),
		.rb_word_out     (rb_word_out),
		.rb_ready_out    (rb_ready_out),
		.bank_b_sel_out  (bank_b_sel_out),
		.gpio_out        (gpio_out),
		.gpio_oe_out     (gpio_oe_out)
	);

	dac_host_model dac_host_model_i (
		.clk_in           (clk_in),
		.frame_strobe_out (frame_strobe_in),
		.frame_word_out   (frame_word_in)
	);

	initial begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end

	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [15:0] lfsr_next(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr_next

	task automatic rnd(output logic [15:0] v);
		lfsr_ff = lfsr_next(lfsr_ff);
		v = lfsr_ff;
	endtask : rnd

	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	// Random low bits unless the pin is read, where the host sends zeros
	task automatic read_reg(input logic [8:0] code, input logic [15:0] exp, input logic zl);
		logic [15:0] r;
		rnd(r);
		exp_q.push_back(exp);
		dac_host_model_i.read_frame(code, zl ? 7'h00 : r[6:0]);
	endtask : read_reg

	task automatic summarize();
		if (bad_count == 0 && num_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : summarize

	////////////////////////////////////////////////////////////////////////////////
	// Compares on the rise of ready only; a second select while ready is not used
	always @(posedge clk_in) begin
		#1;
		if (rb_ready_out === 1'b1 && ready_seen !== 1'b1) begin
			if (exp_q.size() == 0) begin
				check("readback unrequested", 16'h0001, 16'h0000);
			end else begin
				check("readback word", rb_word_out, exp_q.pop_front());
			end
		end
		ready_seen = rb_ready_out;
	end

	initial begin
		repeat (20000) @(posedge clk_in);
		check("watchdog", 16'h0001, 16'h0000);
		summarize();
	end

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		rstn_in       = 1'b0;
		gpio_pin_in   = 1'b0;
		temp_alarm_in = 1'b0;
		ready_seen    = 1'b0;
		lfsr_ff       = 16'h0049;
		bad_count     = 0;
		num_checks    = 0;
		rsv           = '{9'h104, 9'h108, 9'h109, 9'h10a};
		repeat (3) @(posedge clk_in);
		rstn_in <= 1'b1;
		#1;
		check("ready after reset", {15'h0, rb_ready_out}, 16'h0000);
		check("bank after reset", {8'h00, bank_b_sel_out}, 16'h0000);
		check("pin enable after reset", {15'h0, gpio_oe_out}, 16'h0000);
		// Input A with control F2 clear, input B with it set, then offset, gain
		for (int k = 0; k < 4; k++) begin
			if (k < 2) dac_host_model_i.send_frame({2'h0, `SF_CTRL, 13'h0, k[0], 2'h0});
			for (int c = 0; c < 8; c++) begin
				rnd(d);
				mem_w[k][c] = d;
				dac_host_model_i.send_frame({(k < 2) ? `MODE_INPUT : (k == 2) ?
					`MODE_OFFSET : `MODE_GAIN, 3'h0, c[2:0], d});
			end
		end
		for (int k = 0; k < 4; k++) begin
			for (int c = 0; c < 8; c++) begin
				read_reg({1'b0, k[1:0], 3'h0, c[2:0]}, mem_w[k][c], 1'b0);
			end
		end
		temp_alarm_in <= 1'b1;
		dac_host_model_i.send_frame({2'h0, `SF_CTRL, 16'h0005});
		read_reg(`RB_CTRL, 16'h0015, 1'b0);
		for (int j = 0; j < 2; j++) begin
			rnd(d);
			dac_host_model_i.send_frame({2'h0, `SF_OFFSET_DAC_ZERO + 6'(j), d});
			read_reg(`RB_OFFSET_DAC_ZERO + 9'(j), {2'h0, d[13:0]}, 1'b0);
		end
		// Reserved upper bits written as ones must not land
		dac_host_model_i.send_frame({2'h0, `SF_BANK_LO, 16'h00f5});
		dac_host_model_i.send_frame({2'h0, `SF_BANK_HI, 16'h00fa});
		#1;
		check("bank select", {8'h00, bank_b_sel_out}, 16'h00a5);
		read_reg(`RB_BANK_LO, 16'h0005, 1'b0);
		read_reg(`RB_BANK_HI, 16'h000a, 1'b0);
		dac_host_model_i.send_frame({2'h0, `SF_BANK_ALL, 16'h003c});
		#1;
		check("bank block write", {8'h00, bank_b_sel_out}, 16'h003c);
		foreach (rsv[i]) read_reg(rsv[i], 16'h0000, 1'b0);
		#1;
		check("bank after reserved", {8'h00, bank_b_sel_out}, 16'h003c);
		// Pin as input follows the level, as output returns the driven value
		for (int p = 0; p < 2; p++) begin
			rnd(d);
			gpio_pin_in <= d[0];
			dac_host_model_i.send_frame({2'h0, `SF_GPIO, 16'h0000});
			read_reg(`RB_GPIO, {15'h0, d[0]}, 1'b1);
		end
		gpio_pin_in <= 1'b0;
		dac_host_model_i.send_frame({2'h0, `SF_GPIO, 16'h0003});
		#1;
		check("pin drive", {14'h0, gpio_oe_out, gpio_out}, 16'h0003);
		read_reg(`RB_GPIO, 16'h0001, 1'b1);
		repeat (4) @(posedge clk_in);
		check("pending reads", 16'(exp_q.size()), 16'h0000);
		summarize();
	end
endmodule : dac_readback_bank_select_test
`default_nettype wire
